/* File: design/hid_i2c_bridge.sv */
/*
 HID report driven I2C master: command reports in, response reports
 out, vendor identity control request, indirect feature register
 access. Assumes the USB core hands over report bytes as valid/ready
 streams on CLK, and that the I2C wires are open drain with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module hid_i2c_bridge
   import hid_i2c_pkg::*;
#(
   parameter int unsigned FREE_TO_CYC_P = FREE_TO_CYC,
   parameter int unsigned BYTE_TO_CYC_P = BYTE_TO_CYC,
   parameter logic [15:0] VENDOR_ID = 16'h1111, // arbitrary value
   parameter logic [15:0] PRODUCT_ID = 16'h2222, // arbitrary value
   parameter logic [15:0] RELEASE_NUM = 16'h0100 // arbitrary value
)(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic OUT_VALID,
   input wire logic [7:0] OUT_DATA,
   input wire logic OUT_LAST,
   output logic OUT_READY,
   output logic IN_VALID,
   output logic [7:0] IN_DATA,
   output logic IN_LAST,
   input wire logic IN_READY,
   input wire logic SETUP_VALID,
   input wire logic [7:0] SETUP_TYPE,
   input wire logic [7:0] SETUP_REQ,
   input wire logic [15:0] SETUP_LEN,
   output logic CTL_VALID,
   output logic [7:0] CTL_DATA,
   output logic CTL_LAST,
   output logic CTL_STALL,
   input wire logic CTL_READY,
   input wire logic FEAT_VALID,
   input wire logic [7:0] FEAT_ID,
   input wire logic [15:0] FEAT_ADDR,
   input wire logic [15:0] FEAT_WDATA,
   output logic FEAT_RVALID,
   output logic [15:0] FEAT_RDATA,
   output logic REG_WR,
   output logic [15:0] REG_WADDR,
   output logic [15:0] REG_WDATA,
   output logic [15:0] REG_RADDR,
   input wire logic [15:0] REG_RDATA,
   input wire logic LINK_CLK,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SCL_OE,
   output logic SDA_OE
);
   typedef enum logic [6:0] {C_IDLE = 7'h01, C_CHK = 7'h02, C_FREE = 7'h04,
      C_OP = 7'h08, C_WAIT = 7'h10, C_ABORT = 7'h20, C_TX = 7'h40} core_e;
   typedef enum logic [6:0] {PH_START = 7'h01, PH_ADDRW = 7'h02, PH_WR = 7'h04,
      PH_RSTART = 7'h08, PH_ADDRR = 7'h10, PH_RD = 7'h20, PH_STOP = 7'h40,
      PH_DONE = 7'h00} ph_e;
   logic [7:0] cmd_mem [0:CMD_LEN-1];
   logic [7:0] rbuf [0:DATA_MAX-1];
   core_e st_ff;
   ph_e ph_ff;
   ph_e ph_next;
   logic [5:0] rx_cnt_ff;
   logic len_bad_ff;
   logic [5:0] wcnt_ff;
   logic [5:0] rcnt_ff;
   logic [5:0] tx_idx_ff;
   logic [3:0] stat_ff;
   logic held_ff;
   logic [23:0] tmr_ff;
   logic req_ff;
   logic abort_ff;
   op_e op_ff;
   logic [7:0] wbyte_ff;
   logic rack_ff;
   logic [1:0] ack_sync_ff;
   logic [1:0] busy_sync_ff;
   logic [2:0] ctl_idx_ff;
   logic eng_ack;
   logic eng_busy;
   logic eng_nak;
   logic eng_arb;
   logic [7:0] eng_rbyte;

   // command fields as stored
   wire [7:0] flags_w = cmd_mem[OFS_FLAGS];
   wire [7:0] wr_w = cmd_mem[OFS_WR];
   wire [7:0] rd_w = cmd_mem[OFS_RD];
   wire [6:0] taddr = cmd_mem[OFS_ADDR][7:1];
   wire [5:0] wr6 = wr_w[5:0];
   wire [5:0] rd6 = rd_w[5:0];
   wire has_wr = wr6 != 6'h00;
   wire has_rd = rd6 != 6'h00;
   wire wlast = (wcnt_ff + 6'h01) == wr6;
   wire rlast = (rcnt_ff + 6'h01) == rd6;
   wire cmd_bad = len_bad_ff || (cmd_mem[OFS_ID] != REPORT_ID)
      || (wr_w > 8'(DATA_MAX)) || (rd_w > 8'(DATA_MAX));
   wire done_w = ack_sync_ff[1] == req_ff;
   wire busy_s = busy_sync_ff[1];
   wire free_to = tmr_ff >= 24'(FREE_TO_CYC_P);
   wire byte_to = tmr_ff >= 24'(BYTE_TO_CYC_P);
   wire rx_take = OUT_VALID && OUT_READY;

   // phase plan: address only where a start or repeated start leads it
   wire ph_e tail = flags_w[FLG_STOP] ? PH_STOP : PH_DONE;
   wire ph_e after_w = has_rd ? PH_RSTART : tail;
   wire ph_e first = flags_w[FLG_START] ? PH_START
      : has_wr ? PH_WR : has_rd ? PH_RD : tail;
   always_comb
   begin
      case (ph_ff)
         PH_START: ph_next = (!has_wr && has_rd) ? PH_ADDRR : PH_ADDRW;
         PH_ADDRW: ph_next = has_wr ? PH_WR : after_w;
         PH_WR: ph_next = wlast ? after_w : PH_WR;
         PH_RSTART: ph_next = PH_ADDRR;
         PH_ADDRR: ph_next = has_rd ? PH_RD : tail;
         PH_RD: ph_next = rlast ? tail : PH_RD;
         default: ph_next = PH_DONE;
      endcase
   end

   // operation handed to the link engine for the current phase
   wire is_start = (ph_ff == PH_START) || (ph_ff == PH_RSTART);
   wire op_e op_w = is_start ? OP_START : (ph_ff == PH_RD) ? OP_READ
      : (ph_ff == PH_STOP) ? OP_STOP : OP_WRITE;
   wire [7:0] byte_w = (ph_ff == PH_ADDRW) ? {taddr, 1'b0}
      : (ph_ff == PH_ADDRR) ? {taddr, 1'b1}
      : cmd_mem[6'(OFS_DATA) + wcnt_ff];
   wire rack_w = !rlast || flags_w[FLG_ACKLAST];
   wire is_wbyte = (ph_ff == PH_ADDRW) || (ph_ff == PH_ADDRR) || (ph_ff == PH_WR);

   // response bytes
   wire [5:0] tx_sel = (st_ff == C_TX) ? tx_idx_ff + 6'h01 : 6'h00;
   wire [7:0] resp_w = (tx_sel == 6'(OFS_ID)) ? REPORT_ID
      : (tx_sel == 6'(OFS_FLAGS)) ? {flags_w[7:4], stat_ff}
      : (tx_sel == 6'(OFS_WR)) ? {2'h0, wcnt_ff}
      : (tx_sel == 6'(OFS_RD)) ? {2'h0, rcnt_ff}
      : (tx_sel == 6'(OFS_ADDR)) ? RSVD_BYTE
      : rbuf[5'(tx_sel - 6'(OFS_DATA))];
   wire tx_end = tx_sel == 6'(CMD_LEN - 1);

   // report bytes are kept in place; overflow bytes are only counted
   always_ff @(posedge CLK)
   begin
      if (CE && rx_take && (rx_cnt_ff < 6'(CMD_LEN)))
         cmd_mem[rx_cnt_ff] <= OUT_DATA;
   end

   // read bytes land in the response buffer as the engine returns them
   always_ff @(posedge CLK)
   begin
      if (CE && (st_ff == C_WAIT) && done_w && (ph_ff == PH_RD) && !eng_arb)
         rbuf[rcnt_ff[4:0]] <= eng_rbyte;
   end

   // handshake results and bus level come from the link domain
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         ack_sync_ff <= '0;
         busy_sync_ff <= '0;
      end
      else if (CE)
      begin
         ack_sync_ff <= {ack_sync_ff[0], eng_ack};
         busy_sync_ff <= {busy_sync_ff[0], eng_busy};
      end
   end

   // byte and bus-free timer, restarted whenever a wait begins
   always_ff @(posedge CLK)
   begin
      if (!NRST)
         tmr_ff <= '0;
      else if (CE)
         tmr_ff <= ((st_ff == C_FREE) || (st_ff == C_WAIT)) ? tmr_ff + 24'h1 : '0;
   end

   // receive counter: a short or long report is flagged, not dropped
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         rx_cnt_ff <= '0;
         len_bad_ff <= 1'b0;
      end
      else if (CE && rx_take)
      begin
         rx_cnt_ff <= OUT_LAST ? 6'h00 : (rx_cnt_ff == 6'h3f) ? rx_cnt_ff
            : rx_cnt_ff + 6'h01;
         len_bad_ff <= rx_cnt_ff != 6'(CMD_LEN - 1);
      end
   end

   // main sequencer
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         st_ff <= C_IDLE;
         ph_ff <= PH_DONE;
         OUT_READY <= 1'b0;
         {wcnt_ff, rcnt_ff, stat_ff} <= '0;
         {held_ff, req_ff, abort_ff, rack_ff} <= '0;
         op_ff <= OP_START;
         wbyte_ff <= '0;
      end
      else if (CE)
         case (st_ff)
            C_IDLE:
            begin
               OUT_READY <= !(rx_take && OUT_LAST);
               if (rx_take && OUT_LAST)
                  st_ff <= C_CHK;
            end
            C_CHK:
            begin
               {wcnt_ff, rcnt_ff} <= '0;
               stat_ff <= '0;
               ph_ff <= first;
               if (cmd_bad)
               begin
                  stat_ff[ST_INVALID] <= 1'b1;
                  st_ff <= C_TX;
               end
               else if (flags_w[FLG_START] && !held_ff)
                  st_ff <= C_FREE; // fresh start waits for a free bus
               else
                  st_ff <= C_OP; // held bus: repeated start or carry on
            end
            C_FREE:
               if (!busy_s)
                  st_ff <= C_OP;
               else if (free_to)
               begin
                  stat_ff[ST_TIMEOUT] <= 1'b1;
                  st_ff <= C_TX;
               end
            C_OP:
               if (ph_ff == PH_DONE)
                  st_ff <= C_TX;
               else
               begin
                  op_ff <= op_w;
                  wbyte_ff <= byte_w;
                  rack_ff <= rack_w;
                  req_ff <= !req_ff;
                  st_ff <= C_WAIT;
               end
            C_WAIT:
               if (done_w)
               begin
                  if (eng_arb)
                  begin
                     stat_ff[ST_ARB] <= 1'b1;
                     held_ff <= 1'b0;
                     st_ff <= C_TX;
                  end
                  else if (eng_nak && is_wbyte)
                  begin
                     stat_ff[ST_NAK] <= 1'b1;
                     ph_ff <= PH_STOP; // abort releases the bus with a stop
                     held_ff <= 1'b1;
                     st_ff <= C_OP;
                  end
                  else
                  begin
                     if (ph_ff == PH_WR)
                        wcnt_ff <= wcnt_ff + 6'h01;
                     if (ph_ff == PH_RD)
                        rcnt_ff <= rcnt_ff + 6'h01;
                     held_ff <= ph_ff != PH_STOP;
                     ph_ff <= ph_next;
                     st_ff <= C_OP;
                  end
               end
               else if (byte_to)
               begin
                  stat_ff[ST_TIMEOUT] <= 1'b1;
                  abort_ff <= 1'b1;
                  st_ff <= C_ABORT;
               end
            C_ABORT:
               if (done_w)
               begin
                  abort_ff <= 1'b0; // engine has let go of the wire
                  held_ff <= 1'b0;
                  st_ff <= C_TX;
               end
            C_TX:
               if (IN_READY && IN_VALID && IN_LAST)
               begin
                  st_ff <= C_IDLE;
                  OUT_READY <= 1'b1;
               end
            default: st_ff <= C_IDLE;
         endcase
   end

   // response stream: loaded on entry to C_TX, advanced on each take
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         IN_VALID <= 1'b0;
         IN_DATA <= '0;
         IN_LAST <= 1'b0;
         tx_idx_ff <= '0;
      end
      else if (CE)
      begin
         if (st_ff != C_TX)
         begin
            IN_VALID <= 1'b0;
            tx_idx_ff <= '0;
            IN_DATA <= resp_w;
            IN_LAST <= 1'b0;
            if ((st_ff != C_IDLE) && (st_ff != C_TX))
               IN_VALID <= 1'b0;
         end
         else if (!IN_VALID)
         begin
            IN_VALID <= 1'b1;
            IN_DATA <= REPORT_ID;
         end
         else if (IN_READY)
         begin
            IN_VALID <= !IN_LAST;
            IN_DATA <= resp_w;
            IN_LAST <= tx_end;
            tx_idx_ff <= tx_idx_ff + 6'h01;
         end
      end
   end

   // vendor identity answer on the control pipe, little endian words
   wire [63:0] id_w = {16'h0000, RELEASE_NUM, PRODUCT_ID, VENDOR_ID}; // pad past byte 6
   wire id_hit = (SETUP_TYPE == CHIPID_TYPE) && (SETUP_REQ == CHIPID_REQ)
      && (SETUP_LEN == CHIPID_LEN);
   wire [2:0] ctl_sel = ctl_idx_ff + 3'h1;
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         {CTL_VALID, CTL_LAST, CTL_STALL} <= '0;
         CTL_DATA <= '0;
         ctl_idx_ff <= '0;
      end
      else if (CE)
      begin
         CTL_STALL <= SETUP_VALID && !id_hit; // other requests are not ours
         if (SETUP_VALID && id_hit)
         begin
            CTL_VALID <= 1'b1;
            CTL_DATA <= id_w[7:0];
            CTL_LAST <= 1'b0;
            ctl_idx_ff <= '0;
         end
         else if (CTL_VALID && CTL_READY)
         begin
            CTL_VALID <= !CTL_LAST;
            CTL_DATA <= id_w[{ctl_sel, 3'h0} +: 8];
            CTL_LAST <= ctl_sel == CHIPID_LASTIDX;
            ctl_idx_ff <= ctl_sel;
         end
      end
   end

   // feature reports: write direct, read through a latched address
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         {REG_WR, FEAT_RVALID} <= '0;
         {REG_WADDR, REG_WDATA, REG_RADDR, FEAT_RDATA} <= '0;
      end
      else if (CE)
      begin
         REG_WR <= FEAT_VALID && (FEAT_ID == FEAT_WRITE_ID);
         FEAT_RVALID <= FEAT_VALID && (FEAT_ID == FEAT_READ_ID);
         if (FEAT_VALID && (FEAT_ID == FEAT_WRITE_ID))
         begin
            REG_WADDR <= FEAT_ADDR;
            REG_WDATA <= FEAT_WDATA;
         end
         if (FEAT_VALID && (FEAT_ID == FEAT_SETRD_ID))
            REG_RADDR <= FEAT_ADDR;
         if (FEAT_VALID && (FEAT_ID == FEAT_READ_ID))
            FEAT_RDATA <= REG_RDATA;
      end
   end

   // link side; the engine syncs req, abort, reset and enable itself
   i2c_link_engine u_link (
      .lclk(LINK_CLK),
      .nrst(NRST),
      .ce(CE),
      .req_t(req_ff),
      .abort(abort_ff),
      .op(op_ff),
      .wbyte(wbyte_ff),
      .rack(rack_ff),
      .scl_in(SCL_IN),
      .sda_in(SDA_IN),
      .ack_t(eng_ack),
      .rbyte(eng_rbyte),
      .nak(eng_nak),
      .arb(eng_arb),
      .busy(eng_busy),
      .scl_oe(SCL_OE),
      .sda_oe(SDA_OE)
   );
endmodule
`default_nettype wire

/* File: design/hid_i2c_pkg.sv */
/*
 Shared constants and types for the HID report driven I2C master:
 report layout, flag positions, control and feature request codes,
 timeouts and link timing. Assumes a 50 MHz core clock and a
 15.625 MHz link clock.
*/
package hid_i2c_pkg;
   // report layout, same length for command and response
   localparam int CMD_LEN = 37;
   localparam int DATA_MAX = 32;
   localparam int OFS_ID = 0;
   localparam int OFS_FLAGS = 1;
   localparam int OFS_WR = 2;
   localparam int OFS_RD = 3;
   localparam int OFS_ADDR = 4;
   localparam int OFS_DATA = 5;
   localparam logic [7:0] REPORT_ID = 8'h00;
   localparam logic [7:0] RSVD_BYTE = 8'h00;
   // command flag bits
   localparam int FLG_START = 0;
   localparam int FLG_STOP = 1;
   localparam int FLG_ACKLAST = 2;
   // response status bits
   localparam int ST_INVALID = 0;
   localparam int ST_NAK = 1;
   localparam int ST_ARB = 2;
   localparam int ST_TIMEOUT = 3;
   // vendor identity request
   localparam logic [7:0] CHIPID_TYPE = 8'hc0;
   localparam logic [7:0] CHIPID_REQ = 8'hff;
   localparam logic [15:0] CHIPID_LEN = 16'h0006;
   localparam logic [2:0] CHIPID_LASTIDX = 3'h5;
   // feature report identifiers
   localparam logic [7:0] FEAT_WRITE_ID = 8'h3c;
   localparam logic [7:0] FEAT_SETRD_ID = 8'h4b;
   localparam logic [7:0] FEAT_READ_ID = 8'h5a;
   // timeouts
   localparam int CLK_KHZ = 50000;
   localparam int BYTE_TO_MS = 10;
   localparam int FREE_TO_MS = 256;
   localparam int BYTE_TO_CYC = BYTE_TO_MS * CLK_KHZ;
   localparam int FREE_TO_CYC = FREE_TO_MS * CLK_KHZ;
   // link timing: quarter of an scl period in link clocks
   localparam int LINK_KHZ = 15625;
   localparam int SCL_KHZ = 100;
   localparam int QTR_CYC = LINK_KHZ / (4 * SCL_KHZ);
   localparam logic [3:0] ACK_BIT = 4'h8;
   typedef enum logic [1:0] {OP_START = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2,
      OP_STOP = 2'h3} op_e;
endpackage

/* File: design/i2c_link_engine.sv */
/*
 I2C bit engine on the link clock: start, byte write, byte read, stop.
 Assumes the core holds op, wbyte and rack stable while req_t differs
 from ack_t; results are stable once ack_t toggles back to match.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_link_engine
   import hid_i2c_pkg::*;
(
   input wire logic lclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic req_t,
   input wire logic abort,
   input wire op_e op,
   input wire logic [7:0] wbyte,
   input wire logic rack,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic ack_t,
   output logic [7:0] rbyte,
   output logic nak,
   output logic arb,
   output logic busy,
   output logic scl_oe,
   output logic sda_oe
);
   typedef enum logic [1:0] {E_IDLE = 2'h1, E_RUN = 2'h2} eng_e;
   logic [5:0] s1_ff;
   logic [5:0] s2_ff;
   eng_e st_ff;
   op_e op_ff;
   logic [1:0] q_ff;
   logic [5:0] qcnt_ff;
   logic [3:0] bit_ff;
   logic [8:0] tx_ff;
   logic [8:0] rx_ff;
   logic sda_prev_ff;
   logic [8:0] tx_load;
   // reset, enable, req, abort and the pins are two-flop synced; op, wbyte and rack from the core are not
   always_ff @(posedge lclk)
   begin
      s1_ff <= {nrst, ce, req_t, abort, scl_in, sda_in};
      s2_ff <= s1_ff;
   end
   wire rst_n = s2_ff[5];
   wire ce_s = s2_ff[4];
   wire req_s = s2_ff[3];
   wire abort_s = s2_ff[2];
   wire scl_s = s2_ff[1];
   wire sda_s = s2_ff[0];
   wire is_byte = (op_ff == OP_WRITE) || (op_ff == OP_READ);
   wire last_bit = !is_byte || (bit_ff == ACK_BIT);
   wire qdone = qcnt_ff == 6'(QTR_CYC - 1);
   wire stretch = (q_ff == 2'h1) && !scl_s; // slave holds scl low
   wire mine = (op_ff == OP_WRITE) ? (bit_ff != ACK_BIT) : (bit_ff == ACK_BIT);
   // we released sda for a one of our own but someone pulled it low
   wire lost = (q_ff == 2'h1) && is_byte && mine && tx_ff[8] && !sda_s;
   // read releases data bits and drives the ack slot from rack
   assign tx_load = (op == OP_WRITE) ? {wbyte, 1'b1} : {8'hff, ~rack};
   // start and stop seen on the wire give the bus-busy level
   always_ff @(posedge lclk)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         sda_prev_ff <= 1'b1;
      end
      else if (ce_s)
      begin
         sda_prev_ff <= sda_s;
         if (scl_s && sda_prev_ff && !sda_s)
            busy <= 1'b1;
         else if (scl_s && !sda_prev_ff && sda_s)
            busy <= 1'b0;
      end
   end
   // quarter-period sequencer; abort releases the wire and completes
   always_ff @(posedge lclk)
   begin
      if (!rst_n)
      begin
         st_ff <= E_IDLE;
         op_ff <= OP_START;
         {q_ff, qcnt_ff, bit_ff} <= '0;
         {tx_ff, rx_ff, rbyte} <= '0;
         {ack_t, nak, arb, scl_oe, sda_oe} <= '0;
      end
      else if (ce_s)
      begin
         if (abort_s)
         begin
            st_ff <= E_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            ack_t <= req_s;
         end
         else
            case (st_ff)
               E_IDLE:
                  if (req_s != ack_t)
                  begin
                     st_ff <= E_RUN;
                     op_ff <= op;
                     {q_ff, qcnt_ff, bit_ff} <= '0;
                     tx_ff <= tx_load;
                     nak <= 1'b0;
                     arb <= 1'b0;
                     sda_oe <= (op == OP_STOP) || ((op != OP_START) && !tx_load[8]);
                  end
               E_RUN:
                  if (stretch)
                     qcnt_ff <= '0;
                  else if (lost && qdone)
                  begin
                     st_ff <= E_IDLE; // lost arbitration: let go of both lines
                     scl_oe <= 1'b0;
                     sda_oe <= 1'b0;
                     arb <= 1'b1;
                     ack_t <= req_s;
                  end
                  else if (!qdone)
                     qcnt_ff <= qcnt_ff + 6'h01;
                  else
                  begin
                     qcnt_ff <= '0;
                     q_ff <= q_ff + 2'h1;
                     case (q_ff)
                        2'h0: scl_oe <= 1'b0;
                        2'h1:
                        begin
                           rx_ff <= {rx_ff[7:0], sda_s};
                           if (op_ff == OP_START)
                              sda_oe <= 1'b1;
                           if (op_ff == OP_STOP)
                              sda_oe <= 1'b0;
                        end
                        2'h2: scl_oe <= (op_ff != OP_STOP);
                        default:
                           if (last_bit)
                           begin
                              st_ff <= E_IDLE;
                              ack_t <= req_s;
                              rbyte <= rx_ff[8:1];
                              nak <= (op_ff == OP_WRITE) && rx_ff[0];
                           end
                           else
                           begin
                              bit_ff <= bit_ff + 4'h1;
                              tx_ff <= {tx_ff[7:0], 1'b1};
                              sda_oe <= !tx_ff[7];
                           end
                     endcase
                  end
               default: st_ff <= E_IDLE;
            endcase
      end
   end
endmodule
`default_nettype wire

/* File: verif/hid_i2c_bridge_assertions.sv */
/* bridge port checker, bound into the bridge; assumes one core clock domain on CLK */
`timescale 1ns/1ps
`default_nettype none
module hid_i2c_bridge_assertions #(parameter logic [15:0] VENDOR_ID = 16'h1111)(
   input wire logic CLK, NRST, CE, SETUP_VALID, CTL_VALID, CTL_STALL, FEAT_VALID, FEAT_RVALID,
   input wire logic REG_WR, IN_VALID, OUT_READY,
   input wire logic [7:0] SETUP_TYPE, SETUP_REQ, CTL_DATA, FEAT_ID, IN_DATA,
   input wire logic [15:0] SETUP_LEN, FEAT_ADDR, FEAT_WDATA, FEAT_RDATA, REG_WADDR, REG_WDATA,
   input wire logic [15:0] REG_RADDR, REG_RDATA
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // request decodes, taken only on enabled edges
   wire logic id_ok = SETUP_TYPE == 8'hc0 && SETUP_REQ == 8'hff && SETUP_LEN == 16'h0006;
   wire logic fw = CE && FEAT_VALID && FEAT_ID == 8'h3c;
   wire logic fs = CE && FEAT_VALID && FEAT_ID == 8'h4b;
   wire logic fr = CE && FEAT_VALID && FEAT_ID == 8'h5a;
   sequence s_id_req;
      CE && SETUP_VALID && id_ok;
   endsequence
   sequence s_id_ans;
      CTL_VALID && CTL_DATA == VENDOR_ID[7:0];
   endsequence
   a_ident_first: assert property (s_id_req |=> s_id_ans)
      else $error("identity answer missing");
   a_ident_stall: assert property (CE && SETUP_VALID && !id_ok |=> CTL_STALL)
      else $error("unknown request not stalled");
   a_reg_write: assert property (fw |=> REG_WR && REG_WADDR == $past(FEAT_ADDR) && REG_WDATA == $past(FEAT_WDATA))
      else $error("register write wrong");
   a_stray_write: assert property (REG_WR && $past(CE) |-> $past(fw))
      else $error("register write without request");
   a_read_addr: assert property (fs |=> REG_RADDR == $past(FEAT_ADDR))
      else $error("read address not latched");
   a_reg_read: assert property (fr |=> FEAT_RVALID && FEAT_RDATA == $past(REG_RDATA))
      else $error("register read wrong");
   a_read_cause: assert property (FEAT_RVALID && $past(CE) |-> $past(fr))
      else $error("read answer without request");
   a_resp_id: assert property ($rose(IN_VALID) |-> IN_DATA == 8'h00)
      else $error("response id not zero");
   a_one_at_time: assert property (IN_VALID |-> !OUT_READY)
      else $error("command taken during response");
endmodule
bind hid_i2c_bridge hid_i2c_bridge_assertions #(.VENDOR_ID(VENDOR_ID)) u_chk (.*);
`default_nettype wire

/* File: verif/i2c_target_model.sv */
/* i2c target model: acks address and written bytes; needs pulled-up open-drain wires */
`timescale 1ns/1ps
`default_nettype none
module i2c_target_model (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe
);
   int n = -1;
   logic rw = 1'b0;
   initial sda_oe = 1'b0;
   // start restarts the bit count, stop parks it
   always @(negedge sda) if (scl) n = 0;
   always @(posedge sda) if (scl) n = -1;
   logic [7:0] adr = 8'h00;
   logic ack = 1'b0;
   // direction is the eighth bit after a start; the address byte and the
   // master's ack (sda pulled low) in each read ack slot are kept for the bench to inspect
   always @(posedge scl)
   begin
      if (n == 8)
         rw = sda;
      if (n > 0 && n < 9)
         adr = {adr[6:0], sda};
      if (rw && n > 9 && n % 9 == 0)
         ack = !sda;
   end
   // ack slot after the address byte and each written byte; read data stays released so the pull-up reads as ones
   always @(negedge scl) if (n >= 0)
   begin
      n = n + 1;
      sda_oe = n % 9 == 0 && (n == 9 || !rw);
   end
endmodule
`default_nettype wire

/* File: verif/hid_i2c_bridge_tb.sv */
/* bridge testbench; assumes the target model on the wires and short timeouts */
`timescale 1ns/1ps
`default_nettype none
module hid_i2c_bridge_tb;
   import hid_i2c_pkg::*;
   logic CLK = 0, LINK_CLK = 0, NRST = 0, CE = 1, OUT_VALID = 0, OUT_LAST = 0, IN_READY = 1;
   logic SETUP_VALID = 0, CTL_READY = 1, FEAT_VALID = 0, OUT_READY, IN_VALID, IN_LAST;
   logic CTL_VALID, CTL_LAST, CTL_STALL, FEAT_RVALID, REG_WR, SCL_OE, SDA_OE, t_oe;
   logic [7:0] OUT_DATA = 8'h00, SETUP_TYPE = 8'h00, SETUP_REQ = 8'h00, FEAT_ID = 8'h00;
   logic [7:0] IN_DATA, CTL_DATA;
   logic [7:0] r[37];
   logic [15:0] SETUP_LEN = 16'h0000, FEAT_ADDR = 16'h0000, FEAT_WDATA = 16'h0000;
   logic [15:0] FEAT_RDATA, REG_WADDR, REG_WDATA, REG_RADDR;
   logic [47:0] v;
   // register file stand-in and wired-and bus with pull-ups
   wire logic [15:0] REG_RDATA = REG_RADDR ^ 16'h5a5a;
   wire logic SCL_IN = !SCL_OE;
   wire logic SDA_IN = !(SDA_OE || t_oe);
   int n_fail = 0, comparisons = 0, i;
   hid_i2c_bridge #(.FREE_TO_CYC_P(2000), .BYTE_TO_CYC_P(6000)) uut (.*);
   i2c_target_model tgt (.scl(SCL_IN), .sda(SDA_IN), .sda_oe(t_oe));
   initial forever #10 CLK = ~CLK;
   // link clock offset so its edges never line up with the core clock
   initial #7 forever #32 LINK_CLK = ~LINK_CLK;
   task chk(string nm, logic [47:0] s, logic [47:0] e);
      comparisons++;
      if (s !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one command report out, whole response report back
   task cmd(logic [7:0] id, fl, wr, rd, ad);
      for (i = 0; i < 37; i++)
      begin
         while (!OUT_READY) @(negedge CLK);
         OUT_DATA = i == 0 ? id : i == 1 ? fl : i == 2 ? wr : i == 3 ? rd : i == 4 ? ad : 8'h3c;
         OUT_LAST = i == 36;
         OUT_VALID = 1;
         @(negedge CLK);
      end
      OUT_VALID = 0;
      OUT_LAST = 0;
      i = 0;
      while (i < 37)
      begin
         @(negedge CLK);
         if (IN_VALID)
         begin
            r[i] = IN_DATA;
            if (i == 36)
               chk("inlast", IN_LAST, 1);
            i++;
         end
      end
   endtask
   task t_ident;
      SETUP_TYPE = 8'hc0;
      SETUP_REQ = 8'hff;
      SETUP_LEN = 16'h0006;
      SETUP_VALID = 1;
      @(negedge CLK);
      SETUP_VALID = 0;
      for (i = 0; i < 6; i++)
      begin
         v = {v[39:0], CTL_DATA};
         if (i == 5)
            chk("ctllast", CTL_LAST, 1);
         @(negedge CLK);
      end
      chk("ident", v, 48'h111122220001);
      SETUP_REQ = 8'hfe;
      SETUP_VALID = 1;
      @(negedge CLK);
      SETUP_VALID = 0;
      chk("stall", CTL_STALL, 1);
   endtask
   task t_feat;
      {FEAT_ID, FEAT_ADDR, FEAT_WDATA, FEAT_VALID} = {8'h3c, 16'h0341, 16'hbeef, 1'b1};
      @(negedge CLK);
      chk("regwr", {REG_WR, REG_WADDR, REG_WDATA}, {1'b1, 16'h0341, 16'hbeef});
      {FEAT_ID, FEAT_ADDR} = {8'h4b, 16'h0342};
      @(negedge CLK);
      FEAT_VALID = 0;
      @(negedge CLK);
      {FEAT_ID, FEAT_ADDR, FEAT_VALID} = {8'h5a, 16'h0000, 1'b1};
      @(negedge CLK);
      FEAT_VALID = 0;
      chk("regrd", {FEAT_RVALID, FEAT_RDATA}, {1'b1, 16'h5918});
   endtask
   task t_i2c;
      cmd(8'h00, 8'h53, 8'h01, 8'h00, 8'ha1);
      chk("wr", {r[0], r[1], r[2], r[3], r[4]}, 40'h0050010000);
      chk("adr", tgt.adr, 8'ha0);
      cmd(8'h00, 8'ha3, 8'h00, 8'h02, 8'h50);
      chk("rd", {r[1], r[3], r[4], r[5], r[6]}, 40'ha00200ffff);
      chk("rdnak", tgt.ack, 0);
      // ten-bit read: low address byte written, repeated start, read one byte
      cmd(8'h00, 8'h93, 8'h01, 8'h01, 8'hf2);
      chk("ten", {r[1], r[2], r[3], r[5], tgt.adr}, 40'h900101fff3);
      cmd(8'h01, 8'h73, 8'h01, 8'h00, 8'h50);
      chk("badid", {r[1], r[2], r[3]}, 24'h710000);
      cmd(8'h00, 8'h83, 8'h21, 8'h00, 8'h50);
      chk("badwr", {r[1], r[2], r[3]}, 24'h810000);
   endtask
   initial
   begin
      #1500000;
      n_fail++;
      end_sim;
   end
   initial
   begin
      repeat (12) @(negedge CLK);
      NRST = 1;
      t_ident;
      t_feat;
      t_i2c;
      end_sim;
   end
endmodule
`default_nettype wire
